/* logic/lsc_com_scan.sv */
// Common line sequencer with frame polarity
`timescale 1ns/1ps
`default_nettype none
module lsc_com_scan
	import lsc_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	lsc_scan_if.scan  sif
);
	logic [1:0] idx_r;
	logic       pol_r;
	logic       fend_r;

	// ---------------------------------------------------------------
	// One common per step, duty field sets the last common
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || !sif.run) begin
			idx_r  <= 2'h0;
			pol_r  <= 1'b0;
			fend_r <= 1'b0;
		end else begin
			fend_r <= 1'b0;
			if (sif.step) begin
				if (idx_r >= sif.duty) begin
					idx_r  <= 2'h0;
					pol_r  <= ~pol_r;
					fend_r <= 1'b1;
				end else begin
					idx_r <= idx_r + 2'h1;
				end
			end
		end
	end

	assign sif.com_idx   = idx_r;
	assign sif.frame_pol = pol_r;
	assign sif.frame_end = fend_r;
endmodule : lsc_com_scan
`default_nettype wire

/* logic/lsc_lcd_segment_controller.sv */
// Top of the LCD segment controller with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module lsc_lcd_segment_controller
	import lsc_pkg::*;
#(
	parameter int ADDR_W   = LSC_ADDR_W,
	parameter int RELOAD_W = 8
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic [2:0]          s_axi_awprot,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic [2:0]          s_axi_arprot,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Timer 1 count source and reload value
	input  wire logic                timer1_tick,
	input  wire logic [RELOAD_W-1:0] timer1_reload,
	// Panel side
	output logic [7:0]               common_out,
	output logic [63:0]              segment_out,
	output logic [7:0]               segment_oe,
	input  wire logic [7:0]          input_port_four,
	output logic                     bias_divider_en,
	output logic                     system_clock_select
);
	if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk
		$error("lsc_lcd_segment_controller: ADDR_W out of range");
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] addr);
		word_index = addr[11:2];
	endfunction : word_index

	function automatic logic is_ram(input logic [9:0] idx);
		is_ram = (idx >= LSC_IDX_RAM_LO) && (idx <= LSC_IDX_RAM_HI);
	endfunction : is_ram

	function automatic logic is_mapped(input logic [9:0] idx, input logic upper_zero);
		is_mapped = upper_zero && (is_ram(idx) || idx == LSC_IDX_MODE
			|| idx == LSC_IDX_STATUS || idx == LSC_IDX_PORT_IN);
	endfunction : is_mapped

	// Level of a common: selected swings full scale, others sit mid
	function automatic lsc_level_t com_level(input logic sel, input logic pol,
		input logic half);
		if (sel) begin
			com_level = pol ? LSC_LVL_VL3 : LSC_LVL_VSS;
		end else if (half || pol) begin
			com_level = LSC_LVL_VL1;
		end else begin
			com_level = LSC_LVL_VL2;
		end
	endfunction : com_level

	// Level of a segment: lit opposes the selected common
	function automatic lsc_level_t seg_level(input logic lit, input logic pol,
		input logic half);
		if (lit) begin
			seg_level = pol ? LSC_LVL_VSS : LSC_LVL_VL3;
		end else if (half || !pol) begin
			seg_level = LSC_LVL_VL1;
		end else begin
			seg_level = LSC_LVL_VL2;
		end
	endfunction : seg_level

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0]        mode_r;
	logic [7:0]        disp_ram [LSC_NUM_RAM];
	logic [7:0]        port_meta_r;
	logic [7:0]        port_sync_r;
	logic              aw_held_r;
	logic [9:0]        aw_idx_r;
	logic              aw_ok_r;
	logic              w_held_r;
	logic [7:0]        w_byte_r;
	logic              w_lane_r;
	logic              awready_r;
	logic              wready_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              arready_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;
	logic [7:0]        com_r;
	logic [63:0]       seg_r;
	logic [7:0]        seg_oe_r;
	logic              bias_en_r;
	logic              sysclk_r;
	logic              do_write;
	logic [3:0]        aw_ram_sel;
	logic [9:0]        ar_idx;
	logic              ar_upper_zero;
	logic              aw_upper_zero;
	logic [7:0]        rd_byte;
	logic [LSC_NUM_COM*2-1:0] com_nxt;
	logic [LSC_NUM_SEG*2-1:0] seg_nxt;

	lsc_scan_if sif ();

	// ---------------------------------------------------------------
	// Scan timing
	// ---------------------------------------------------------------
	assign sif.run  = mode_r[LSC_BIT_ON];
	assign sif.duty = mode_r[LSC_BIT_DUTY_HI:LSC_BIT_DUTY_LO];

	lsc_step_div #(
		.RELOAD_W      (RELOAD_W)
	) u_div (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.timer1_tick   (timer1_tick),
		.timer1_reload (timer1_reload),
		.sif           (sif)
	);

	lsc_com_scan u_scan (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sif     (sif)
	);

	// ---------------------------------------------------------------
	// Write channels: address and data taken in either order
	// ---------------------------------------------------------------
	assign aw_upper_zero = (ADDR_W == 12) ? 1'b1 : (s_axi_awaddr >> 12) == '0;
	assign do_write      = aw_held_r && w_held_r && !bvalid_r;
	assign aw_ram_sel    = aw_idx_r[3:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_idx_r  <= 10'h000;
			aw_ok_r   <= 1'b0;
			awready_r <= 1'b0;
		end else begin
			awready_r <= 1'b0;
			if (s_axi_awvalid && !aw_held_r && !awready_r) begin
				awready_r <= 1'b1;
				aw_held_r <= 1'b1;
				aw_idx_r  <= word_index(s_axi_awaddr);
				aw_ok_r   <= is_mapped(word_index(s_axi_awaddr), aw_upper_zero);
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_byte_r <= 8'h00;
			w_lane_r <= 1'b0;
			wready_r <= 1'b0;
		end else begin
			wready_r <= 1'b0;
			if (s_axi_wvalid && !w_held_r && !wready_r) begin
				wready_r <= 1'b1;
				w_held_r <= 1'b1;
				w_byte_r <= s_axi_wdata[7:0];
				w_lane_r <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= LSC_RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= aw_ok_r ? LSC_RESP_OKAY : LSC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Control register and display RAM
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= LSC_MODE_RST;
		end else if (do_write && w_lane_r && aw_ok_r && aw_idx_r == LSC_IDX_MODE) begin
			mode_r <= w_byte_r & LSC_MODE_WMASK;
		end
	end

	// Pattern is not cleared by reset; software loads it first
	always_ff @(posedge aclk) begin
		if (do_write && w_lane_r && aw_ok_r && is_ram(aw_idx_r)) begin
			disp_ram[aw_ram_sel] <= w_byte_r;
		end
	end

	// ---------------------------------------------------------------
	// Shared pins read back as a port
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_meta_r <= 8'h00;
			port_sync_r <= 8'h00;
		end else begin
			port_meta_r <= input_port_four;
			port_sync_r <= port_meta_r;
		end
	end

	// ---------------------------------------------------------------
	// Read channel: one cycle from address to data
	// ---------------------------------------------------------------
	assign ar_idx        = word_index(s_axi_araddr);
	assign ar_upper_zero = (ADDR_W == 12) ? 1'b1 : (s_axi_araddr >> 12) == '0;

	always_comb begin
		rd_byte = 8'h00;
		if (is_ram(ar_idx)) begin
			rd_byte = disp_ram[ar_idx[3:0]];
		end else if (ar_idx == LSC_IDX_MODE) begin
			rd_byte = mode_r;
		end else if (ar_idx == LSC_IDX_STATUS) begin
			rd_byte = {4'h0, bias_en_r, sif.frame_pol, sif.com_idx};
		end else if (ar_idx == LSC_IDX_PORT_IN) begin
			rd_byte = mode_r[LSC_BIT_PORTSEL] ? 8'h00 : port_sync_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= LSC_RESP_OKAY;
		end else begin
			arready_r <= 1'b0;
			if (s_axi_arvalid && !rvalid_r && !arready_r) begin
				arready_r <= 1'b1;
				rvalid_r  <= 1'b1;
				if (is_mapped(ar_idx, ar_upper_zero)) begin
					rdata_r <= {24'h00_0000, rd_byte};
					rresp_r <= LSC_RESP_OKAY;
				end else begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= LSC_RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Drive levels for commons and segments
	// ---------------------------------------------------------------
	for (genvar c = 0; c < LSC_NUM_COM; c++) begin : g_com
		assign com_nxt[2*c +: 2] = com_level(sif.com_idx == 2'(c), sif.frame_pol,
			mode_r[LSC_BIT_BIAS]);
	end

	for (genvar s = 0; s < LSC_NUM_SEG; s++) begin : g_seg
		assign seg_nxt[2*s +: 2] = seg_level(
			disp_ram[s/2][(s%2)*4 + int'(sif.com_idx)],
			sif.frame_pol, mode_r[LSC_BIT_BIAS]);
	end

	// Blanking pulls every pin to ground so the glass sees no DC
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			com_r <= 8'h00;
			seg_r <= 64'h0000_0000_0000_0000;
		end else if (!mode_r[LSC_BIT_ON]) begin
			com_r <= 8'h00;
			seg_r <= 64'h0000_0000_0000_0000;
		end else begin
			com_r <= com_nxt;
			seg_r <= seg_nxt;
			if (!mode_r[LSC_BIT_PORTSEL]) begin
				seg_r[2*LSC_SHARED_FIRST +: 2*LSC_NUM_SHARED] <= 16'h0000;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seg_oe_r  <= 8'h00;
			bias_en_r <= 1'b0;
			sysclk_r  <= 1'b0;
		end else begin
			seg_oe_r  <= {LSC_NUM_SHARED{mode_r[LSC_BIT_PORTSEL]}};
			bias_en_r <= mode_r[LSC_BIT_ON];
			sysclk_r  <= mode_r[LSC_BIT_SYSCLK];
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign s_axi_awready       = awready_r;
	assign s_axi_wready        = wready_r;
	assign s_axi_bvalid        = bvalid_r;
	assign s_axi_bresp         = bresp_r;
	assign s_axi_arready       = arready_r;
	assign s_axi_rvalid        = rvalid_r;
	assign s_axi_rdata         = rdata_r;
	assign s_axi_rresp         = rresp_r;
	assign common_out          = com_r;
	assign segment_out         = seg_r;
	assign segment_oe          = seg_oe_r;
	assign bias_divider_en     = bias_en_r;
	assign system_clock_select = sysclk_r;

endmodule : lsc_lcd_segment_controller
`default_nettype wire

/* logic/lsc_pkg.sv */
// Shared constants and types of the LCD segment controller
package lsc_pkg;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam int         LSC_ADDR_W       = 12;
	localparam logic [9:0] LSC_IDX_MODE     = 10'h0f5;
	localparam logic [9:0] LSC_IDX_RAM_LO   = 10'h0d0;
	localparam logic [9:0] LSC_IDX_RAM_HI   = 10'h0df;
	localparam logic [9:0] LSC_IDX_STATUS   = 10'h0c0;
	localparam logic [9:0] LSC_IDX_PORT_IN  = 10'h0c1;

	// ---------------------------------------------------------------
	// Display control register layout
	// ---------------------------------------------------------------
	localparam logic [7:0] LSC_MODE_RST     = 8'h00;
	localparam logic [7:0] LSC_MODE_WMASK   = 8'h9f;
	localparam int         LSC_BIT_DUTY_LO  = 0;
	localparam int         LSC_BIT_DUTY_HI  = 1;
	localparam int         LSC_BIT_BIAS     = 2;
	localparam int         LSC_BIT_ON       = 3;
	localparam int         LSC_BIT_PORTSEL  = 4;
	localparam int         LSC_BIT_SYSCLK   = 7;

	// ---------------------------------------------------------------
	// Display geometry and scan timing
	// ---------------------------------------------------------------
	localparam int         LSC_NUM_COM      = 4;
	localparam int         LSC_NUM_SEG      = 32;
	localparam int         LSC_NUM_RAM      = 16;
	localparam int         LSC_SHARED_FIRST = 24;
	localparam int         LSC_NUM_SHARED   = 8;
	localparam logic [1:0] LSC_QUARTER_LAST = 2'h3;

	// ---------------------------------------------------------------
	// Bus answers and drive levels
	// ---------------------------------------------------------------
	localparam logic [1:0] LSC_RESP_OKAY    = 2'h0;
	localparam logic [1:0] LSC_RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		LSC_LVL_VSS = 2'b00,
		LSC_LVL_VL1 = 2'b01,
		LSC_LVL_VL2 = 2'b10,
		LSC_LVL_VL3 = 2'b11
	} lsc_level_t;

endpackage : lsc_pkg

/* logic/lsc_scan_if.sv */
// Scan timing signals shared between divider, scanner and core
`timescale 1ns/1ps
`default_nettype none
interface lsc_scan_if;
	logic       run;
	logic [1:0] duty;
	logic       step;
	logic [1:0] com_idx;
	logic       frame_pol;
	logic       frame_end;

	modport div  (input run, output step);
	modport scan (input run, input duty, input step, output com_idx, output frame_pol,
		output frame_end);
	modport core (output run, output duty, input step, input com_idx, input frame_pol,
		input frame_end);
endinterface : lsc_scan_if
`default_nettype wire

/* logic/lsc_step_div.sv */
// Scan step divider from the timer 1 count source
`timescale 1ns/1ps
`default_nettype none
module lsc_step_div
	import lsc_pkg::*;
#(
	parameter int RELOAD_W = 8
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                timer1_tick,
	input  wire logic [RELOAD_W-1:0] timer1_reload,
	lsc_scan_if.div                  sif
);
	if (RELOAD_W < 1 || RELOAD_W > 16) begin : g_chk
		$error("lsc_step_div: RELOAD_W out of range");
	end

	logic [RELOAD_W-1:0] cnt_r;
	logic [1:0]          quarter_r;
	logic                step_r;
	logic                underflow;

	assign underflow = timer1_tick && (cnt_r == '0);

	// ---------------------------------------------------------------
	// Timer 1 image: period of reload plus one source ticks
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || !sif.run) begin
			cnt_r <= '0;
		end else if (underflow) begin
			cnt_r <= timer1_reload;
		end else if (timer1_tick) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Divide underflows by four into one step pulse
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || !sif.run) begin
			quarter_r <= 2'h0;
			step_r    <= 1'b0;
		end else begin
			if (underflow) begin
				quarter_r <= quarter_r + 2'h1;
			end
			step_r <= underflow && (quarter_r == LSC_QUARTER_LAST);
		end
	end

	assign sif.step = step_r;
endmodule : lsc_step_div
`default_nettype wire

/* test/lsc_ctrl_checker.sv */
// Concurrent checks on the controller's bus and panel ports
`timescale 1ns/1ps
`default_nettype none
module lsc_ctrl_checker
	import lsc_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [7:0]  common_out,
	input wire logic [63:0] segment_out,
	input wire logic [7:0]  segment_oe,
	input wire logic        bias_divider_en
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------
	// Commons at a full-swing level
	// ------
	logic [2:0] sel_n;
	always_comb begin
		sel_n = 3'h0;
		for (int i = 0; i < 4; i++) begin
			if (common_out[2*i+:2] == LSC_LVL_VSS || common_out[2*i+:2] == LSC_LVL_VL3) begin
				sel_n = sel_n + 3'h1;
			end
		end
	end
	// ------
	// Assertions
	// ------
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready too long");
	ar_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
		else $error("read not answered");
	r_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read upper bits set");
	b_after_a: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
		else $error("write not answered");
	b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid repeated");
	r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid repeated");
	oe_uniform_a: assert property (segment_oe == 8'h00 || segment_oe == 8'hff)
		else $error("shared pins split");
	shared_idle_a: assert property (segment_oe == 8'h00 && $past(segment_oe) == 8'h00
		|-> segment_out[63:48] == 16'h0) else $error("port pins driven");
	one_com_a: assert property (bias_divider_en && common_out != 8'h00 |-> sel_n == 3'h1)
		else $error("not one common selected");
	blank_off_a: assert property ($fell(bias_divider_en)
		|-> ##[0:2] (common_out == 8'h00 && segment_out == 64'h0)) else $error("not blanked");
endmodule : lsc_ctrl_checker
bind lsc_lcd_segment_controller lsc_ctrl_checker u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .common_out(common_out),
	.segment_out(segment_out), .segment_oe(segment_oe), .bias_divider_en(bias_divider_en)
);
`default_nettype wire

/* test/lsc_lcd_segment_controller_test.sv */
// Self-checking bench for the LCD segment controller
`timescale 1ns/1ps
`default_nettype none
module lsc_lcd_segment_controller_test
	import lsc_pkg::*;
();
	// ------
	// Signals and bench state
	// ------
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr  = 12'h0;
	logic        awvalid = 1'b0;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'h0;
	logic        wvalid  = 1'b0;
	logic [11:0] araddr  = 12'h0;
	logic        arvalid = 1'b0;
	logic        bready  = 1'b0;
	logic        rready  = 1'b0;
	logic        tick    = 1'b0;
	logic [7:0]  reload  = 8'h0;
	logic [7:0]  key     = 8'h0;
	logic        awready, wready, bvalid, arready, rvalid, bias_en, clk_sel;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [7:0]  common_out, segment_oe, port_pins, ctrl;
	logic [63:0] segment_out;
	logic [7:0]  ram [16];
	logic [33:0] rq [$];
	logic [1:0]  bq [$];
	bit          watch, ppol;
	int          num_errors, comparisons, cyc, nchg, gap, psel;

	always #2 aclk = ~aclk;

	lsc_lcd_segment_controller #(.ADDR_W(12), .RELOAD_W(8)) DUT (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer1_tick(tick),
		.timer1_reload(reload), .common_out(common_out), .segment_out(segment_out),
		.segment_oe(segment_oe), .input_port_four(port_pins), .bias_divider_en(bias_en),
		.system_clock_select(clk_sel)
	);
	lsc_panel_model panel (.aclk(aclk), .segment_oe(segment_oe), .key_level(key),
		.input_port_four(port_pins));

	// ------
	// Tasks
	// ------
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	function automatic logic [11:0] adr(input logic [9:0] idx);
		return {idx, 2'b00};
	endfunction : adr

	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st,
		input logic [1:0] rsp);
		bit ga, gw;
		ga = 0;
		gw = 0;
		bq.push_back(rsp);
		awaddr <= a;
		wdata <= {24'($urandom()), d};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ga && gw)) begin
			@(posedge aclk);
			if (awready) begin
				ga = 1;
				awvalid <= 1'b0;
			end
			if (wready) begin
				gw = 1;
				wvalid <= 1'b0;
			end
		end
		// Response channel opened once both halves are taken
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [33:0] exp);
		rq.push_back(exp);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge aclk);
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	// ------
	// Monitors
	// ------
	always @(posedge aclk) begin
		if (aresetn && rvalid) chk({rresp, rdata}, rq.pop_front(), "read");
		if (aresetn && bvalid) chk(bresp, bq.pop_front(), "bresp");
		cyc++;
		if (cyc == 10000) begin
			num_errors++;
			$display("unexpected at %0t: run did not finish", $time);
			final_report();
		end
	end

	always @(posedge aclk) begin : pmon
		int sel, ns;
		bit pol, lit;
		logic [1:0] e, lv;
		if (watch) begin
			ns = 0;
			for (int i = 0; i < 4; i++) begin
				lv = common_out[2*i+:2];
				if (lv === LSC_LVL_VSS || lv === LSC_LVL_VL3) begin
					ns++;
					sel = i;
					pol = (lv === LSC_LVL_VL3);
				end
			end
			chk(ns, 1, "selected commons");
			chk(sel <= ctrl[1:0], 1, "common beyond duty");
			for (int s = 0; s < 32; s++) begin
				lit = ram[s / 2][(s % 2) * 4 + sel];
				e = pol ? (lit ? LSC_LVL_VSS : (ctrl[2] ? LSC_LVL_VL1 : LSC_LVL_VL2))
					: (lit ? LSC_LVL_VL3 : LSC_LVL_VL1);
				if (s >= 24 && !ctrl[4]) e = LSC_LVL_VSS;
				chk(segment_out[2*s+:2], e, "segment level");
			end
			if (sel != psel || pol != ppol) begin
				if (nchg > 1) begin
					chk(gap, 4 * (reload + 1), "step period");
					chk(sel, (psel == ctrl[1:0]) ? 0 : psel + 1, "next common");
					chk(pol, ppol ^ (sel == 0), "frame polarity");
				end
				nchg++;
				gap = 0;
			end
			gap++;
			psel = sel;
			ppol = pol;
		end
	end

	// ------
	// Main sequence
	// ------
	initial begin
		void'($urandom(1294));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(adr(LSC_IDX_MODE), {26'h0, LSC_MODE_RST});
		chk({bias_en, clk_sel, segment_oe, common_out, |segment_out}, 0, "reset");
		$display("test reset done");
		for (int k = 0; k < 16; k++) begin
			ram[k] = 8'($urandom());
			wr(adr(LSC_IDX_RAM_LO + 10'(k)), ram[k], 4'h1, LSC_RESP_OKAY);
		end
		wr(adr(LSC_IDX_RAM_LO), ~ram[0], 4'h0, LSC_RESP_OKAY);
		wr(12'h3fc, 8'h5a, 4'h1, LSC_RESP_SLVERR);
		rd(12'h3fc, {LSC_RESP_SLVERR, 32'h0});
		for (int k = 0; k < 16; k++) begin
			rd(adr(LSC_IDX_RAM_LO + 10'(k)), {26'h0, ram[k]});
		end
		$display("test display memory done");
		for (int m = 0; m < 8; m++) begin
			ctrl = {1'($urandom()), 2'h0, 1'($urandom()), 1'b1, 1'(m / 4), 2'(m)};
			reload <= 8'($urandom_range(3));
			key <= 8'($urandom());
			tick <= 1'b1;
			wr(adr(LSC_IDX_MODE), ctrl | {1'b0, 2'($urandom()), 5'h0}, 4'h1, LSC_RESP_OKAY);
			// Let a common left beyond a shorter duty wrap and the new reload settle
			repeat (40) @(posedge aclk);
			rd(adr(LSC_IDX_MODE), {26'h0, ctrl});
			rd(adr(LSC_IDX_PORT_IN), {26'h0, (ctrl[4] ? 8'h0 : key)});
			chk({clk_sel, bias_en, segment_oe}, {ctrl[7], 1'b1, {8{ctrl[4]}}}, "pins");
			nchg <= 0;
			watch <= 1'b1;
			repeat (300) @(posedge aclk);
			watch <= 1'b0;
			// Keeps the scan monitor from seeing the next mode at this edge
			@(posedge aclk);
			$display("test scan mode %0d done", m);
		end
		wr(adr(LSC_IDX_MODE), 8'h10, 4'h1, LSC_RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk({bias_en, common_out, |segment_out}, 0, "blank");
		rd(adr(LSC_IDX_STATUS), 34'h0);
		$display("test display off done");
		final_report();
	end
endmodule : lsc_lcd_segment_controller_test
`default_nettype wire

/* test/lsc_panel_model.sv */
// Panel side of the shared segment and input port pins
`timescale 1ns/1ps
`default_nettype none
module lsc_panel_model (
	input  wire logic       aclk,
	input  wire logic [7:0] segment_oe,
	input  wire logic [7:0] key_level,
	output logic [7:0]      input_port_four
);
	logic [7:0] flip_r = 8'h5a;
	always @(posedge aclk) begin
		flip_r <= ~flip_r;
	end
	// Driven pins show a moving pattern, so a stale key level cannot pass
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			input_port_four[i] = segment_oe[i] ? flip_r[i] : key_level[i];
		end
	end
endmodule : lsc_panel_model
`default_nettype wire
